// ### rtl/mic_irq_ctrl.sv
// interrupt controller: sources, enables, vectoring and register slave
//
// What this block does
// (R1) Five request sources on the full variant, four without the host port.
// (R2) Global enable bit 7 of control lets unmasked requests through, else blocks all.
// (R3) Every reset clears the global enable so nothing is taken.
// (R4) Return from handler pops the address and sets the global enable again.
// (R5) Core flags and enables sit in control; peripheral ones need peripheral enable.
// (R6) Host and compare flags sit in the flag register, enables in the enable register.
// (R7) Taking a request clears global enable, pushes return address, loads vector 0004h.
// (R8) Handler polls flags and clears serviced ones before enabling again.
// (R9) Edge and port change events reach the vector in five or six cycles.
// (R10) Flags set on their event whatever the enables say.
// (R11) Clearing global enable blocks next-cycle requests, forces a no-op, keeps them pending.
// (R12) Only the return address is saved on entry; no other state.
// (R13) Host flag bit 7 sets on each finished host port access, stays until cleared.
// (R14) Compare flag bit 6 sets on any comparator output change, software clears it.
// (R15) Request is global enable and an enabled core or gated peripheral flag.
`timescale 1ns/1ps

module mic_irq_ctrl #(
  parameter bit HAS_HOST_PORT = mic_pkg::MIC_HAS_HOST_PORT
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            edge_irq_pin_i,
  input  wire logic [mic_pkg::MIC_PORT_PINS-1:0] port_change_pins_i,
  input  wire logic [mic_pkg::MIC_CMP_OUTS-1:0]  compare_out_i,
  input  wire logic                            timer_zero_ovf_i,
  input  wire logic                            host_port_done_i,
  input  wire logic                            ret_from_irq_i,
  input  wire logic [12:0]                     return_pc_i,
  output logic                                 core_irq_req_o,
  output logic                                 core_nop_o,
  output logic                                 vector_load_o,
  output logic [12:0]                          vector_addr_o,
  output logic                                 stack_push_o,
  output logic [12:0]                          stack_push_pc_o,
  output logic                                 stack_pop_o,
  output logic                                 irq_o,
  input  wire logic [7:0]                      s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [7:0]                      s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready
);
  import mic_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    mic_state_t                  state;
    logic                        global_irq_enable, peripheral_irq_enable, tmr_en, edge_en, port_en;
    logic                        tmr_f, edge_f, port_f, host_f, cmp_f, host_en, cmp_en;
    logic [MIC_EV_WIDTH-1:0]     ev_stat;
    logic [MIC_EV_WIDTH-1:0]     ev_en;
    logic [2:0]                  edge_s;
    logic                        edge_flt;
    logic [1:0]                  warm;
    logic [MIC_PORT_PINS-1:0]    pc_s1, pc_s2, pc_s3, pc_flt;
    logic [MIC_CMP_OUTS-1:0]     cm_s1, cm_s2, cm_s3, cm_flt;
    logic                        aw_full, w_full, w_lane0;
    logic [7:0]                  aw_addr;
    logic [7:0]                  w_data;
    logic                        awready, wready, bvalid;
    logic [1:0]                  bresp;
    logic                        arready, rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic                        req, nop, vec, push, pop, irq;
    logic [12:0]                 vec_addr;
    logic [12:0]                 push_pc;
  } mic_st_t;

  mic_st_t                  st_q;
  mic_st_t                  st_d;
  logic                     edge_evt;
  logic                     port_evt;
  logic                     cmp_evt;
  logic                     host_evt;
  logic                     wr_fire;
  logic                     gie_clr_wr;
  logic [MIC_PORT_PINS-1:0] pc_agree;
  logic [MIC_CMP_OUTS-1:0]  cm_agree;
  mic_sel_t                 wsel;
  mic_sel_t                 rsel;
  logic [31:0]              rd_word;

  function automatic mic_sel_t mic_decode(input logic [7:0] addr);
    mic_sel_t sel;
    sel = MIC_SEL_NONE;
    if (addr == MIC_OFS_CTRL) sel = MIC_SEL_CTRL;
    else if (addr == MIC_OFS_PFLAG) sel = MIC_SEL_PFLAG;
    else if (addr == MIC_OFS_PEN) sel = MIC_SEL_PEN;
    else if (addr == MIC_OFS_ISTAT) sel = MIC_SEL_ISTAT;
    else if (addr == MIC_OFS_ICLR) sel = MIC_SEL_ICLR;
    else if (addr == MIC_OFS_IEN) sel = MIC_SEL_IEN;
    return sel;
  endfunction

  function automatic logic mic_pending(input mic_st_t s);
    logic core_hit;
    logic peri_hit;
    core_hit = (s.edge_f & s.edge_en) | (s.tmr_f & s.tmr_en) | (s.port_f & s.port_en);
    peri_hit = s.peripheral_irq_enable & ((s.host_f & s.host_en) | (s.cmp_f & s.cmp_en));  // see R5
    return s.global_irq_enable & (core_hit | peri_hit);  // see R15 see R2
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    st_d     = st_q;
    rd_word  = 32'h0;
    wsel     = mic_decode(st_q.aw_addr);
    rsel     = mic_decode(s_axi_araddr);
    st_d.vec  = 1'b0;
    st_d.push = 1'b0;
    st_d.pop  = 1'b0;

    // pin inputs: three stages, a change (on the edge pin only a rise) counts once stages two and three agree
    st_d.edge_s = {st_q.edge_s[1:0], edge_irq_pin_i};
    edge_evt    = (st_q.edge_s[1] == st_q.edge_s[2]) & st_q.edge_s[2] & ~st_q.edge_flt;
    if (st_q.edge_s[1] == st_q.edge_s[2]) begin
      st_d.edge_flt = st_q.edge_s[2];
    end
    st_d.pc_s1 = port_change_pins_i;
    st_d.pc_s2 = st_q.pc_s1;
    st_d.pc_s3 = st_q.pc_s2;
    // chain fills before changes count, so the idle pin level after reset is no event
    st_d.warm  = (st_q.warm == 2'h3) ? 2'h3 : st_q.warm + 2'h1;
    pc_agree   = ~(st_q.pc_s2 ^ st_q.pc_s3);
    port_evt   = (st_q.warm == 2'h3) & |(pc_agree & (st_q.pc_s3 ^ st_q.pc_flt));
    st_d.pc_flt = (st_q.warm == 2'h3) ? ((pc_agree & st_q.pc_s3) | (~pc_agree & st_q.pc_flt))
                                      : st_q.pc_s2;
    st_d.cm_s1 = compare_out_i;
    st_d.cm_s2 = st_q.cm_s1;
    st_d.cm_s3 = st_q.cm_s2;
    cm_agree   = ~(st_q.cm_s2 ^ st_q.cm_s3);
    cmp_evt    = (st_q.warm == 2'h3) & |(cm_agree & (st_q.cm_s3 ^ st_q.cm_flt));  // see R14
    st_d.cm_flt = (st_q.warm == 2'h3) ? ((cm_agree & st_q.cm_s3) | (~cm_agree & st_q.cm_flt))
                                      : st_q.cm_s2;
    host_evt   = host_port_done_i & HAS_HOST_PORT;  // see R1

    // write channel
    wr_fire    = st_q.aw_full & st_q.w_full & ~st_q.bvalid;
    gie_clr_wr = 1'b0;
    if (st_q.bvalid & s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (wsel == MIC_SEL_NONE) ? MIC_RESP_SLVERR : MIC_RESP_OKAY;
      if (st_q.w_lane0) begin
        unique case (wsel)
          MIC_SEL_CTRL: begin
            st_d.global_irq_enable     = st_q.w_data[MIC_CTRL_GIE_BIT];
            st_d.peripheral_irq_enable    = st_q.w_data[MIC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
            st_d.tmr_en  = st_q.w_data[MIC_CTRL_TMREN_BIT];
            st_d.edge_en = st_q.w_data[MIC_CTRL_EDGEN_BIT];
            st_d.port_en = st_q.w_data[MIC_CTRL_PRTEN_BIT];
            st_d.tmr_f   = st_q.w_data[MIC_CTRL_TMRF_BIT];
            st_d.edge_f  = st_q.w_data[MIC_CTRL_EDGF_BIT];
            st_d.port_f  = st_q.w_data[MIC_CTRL_PRTF_BIT];
            gie_clr_wr   = st_q.global_irq_enable & ~st_q.w_data[MIC_CTRL_GIE_BIT];  // see R11
          end
          MIC_SEL_PFLAG: begin
            st_d.host_f = st_q.w_data[MIC_HOST_BIT] & HAS_HOST_PORT;  // see R6
            st_d.cmp_f  = st_q.w_data[MIC_CMP_BIT];
          end
          MIC_SEL_PEN: begin
            st_d.host_en = st_q.w_data[MIC_HOST_BIT] & HAS_HOST_PORT;  // see R6
            st_d.cmp_en  = st_q.w_data[MIC_CMP_BIT];
          end
          MIC_SEL_ICLR:  st_d.ev_stat = st_q.ev_stat & ~st_q.w_data[MIC_EV_WIDTH-1:0];
          MIC_SEL_IEN:   st_d.ev_en = st_q.w_data[MIC_EV_WIDTH-1:0];
          MIC_SEL_ISTAT, MIC_SEL_NONE: st_d.ev_stat = st_q.ev_stat;
        endcase
      end
    end
    if (s_axi_awvalid & st_q.awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & st_q.wready) begin
      st_d.w_full  = 1'b1;
      st_d.w_data  = s_axi_wdata[7:0];
      st_d.w_lane0 = s_axi_wstrb[0];
    end
    st_d.awready = ~st_d.aw_full & ~st_d.bvalid;
    st_d.wready  = ~st_d.w_full & ~st_d.bvalid;

    // read channel
    unique case (rsel)
      MIC_SEL_CTRL: begin
        rd_word[MIC_CTRL_GIE_BIT]   = st_q.global_irq_enable;
        rd_word[MIC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT]  = st_q.peripheral_irq_enable;
        rd_word[MIC_CTRL_TMREN_BIT] = st_q.tmr_en;
        rd_word[MIC_CTRL_EDGEN_BIT] = st_q.edge_en;
        rd_word[MIC_CTRL_PRTEN_BIT] = st_q.port_en;
        rd_word[MIC_CTRL_TMRF_BIT]  = st_q.tmr_f;
        rd_word[MIC_CTRL_EDGF_BIT]  = st_q.edge_f;
        rd_word[MIC_CTRL_PRTF_BIT]  = st_q.port_f;
      end
      MIC_SEL_PFLAG: begin
        rd_word[MIC_HOST_BIT] = st_q.host_f;
        rd_word[MIC_CMP_BIT]  = st_q.cmp_f;
      end
      MIC_SEL_PEN: begin
        rd_word[MIC_HOST_BIT] = st_q.host_en;
        rd_word[MIC_CMP_BIT]  = st_q.cmp_en;
      end
      MIC_SEL_ISTAT: rd_word[MIC_EV_WIDTH-1:0] = st_q.ev_stat;
      MIC_SEL_IEN:   rd_word[MIC_EV_WIDTH-1:0] = st_q.ev_en;
      MIC_SEL_ICLR, MIC_SEL_NONE: rd_word = 32'h0;
    endcase
    if (st_q.rvalid & s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid & st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_word;
      st_d.rresp  = (rsel == MIC_SEL_NONE) ? MIC_RESP_SLVERR : MIC_RESP_OKAY;
    end
    st_d.arready = ~st_d.rvalid;

    // events set flags after software writes, so a same-cycle set wins
    if (edge_evt) st_d.edge_f = 1'b1;  // see R10
    if (timer_zero_ovf_i) st_d.tmr_f = 1'b1;  // see R10
    if (port_evt) st_d.port_f = 1'b1;  // see R10
    if (cmp_evt) st_d.cmp_f = 1'b1;  // see R14
    if (host_evt) st_d.host_f = 1'b1;  // see R13
    st_d.ev_stat[MIC_EV_EDGE]  = st_d.ev_stat[MIC_EV_EDGE] | edge_evt;
    st_d.ev_stat[MIC_EV_TIMER] = st_d.ev_stat[MIC_EV_TIMER] | timer_zero_ovf_i;
    st_d.ev_stat[MIC_EV_PORT]  = st_d.ev_stat[MIC_EV_PORT] | port_evt;
    st_d.ev_stat[MIC_EV_CMP]   = st_d.ev_stat[MIC_EV_CMP] | cmp_evt;
    st_d.ev_stat[MIC_EV_HOST]  = st_d.ev_stat[MIC_EV_HOST] | host_evt;

    // leaving the handler re-enables and pops the saved address
    if (ret_from_irq_i) begin
      st_d.global_irq_enable = 1'b1;  // see R4
      st_d.pop = 1'b1;  // see R4
    end

    // vectoring: one flushed cycle, then push and jump
    unique case (st_q.state)
      MIC_IDLE: begin
        if (mic_pending(st_q) & ~gie_clr_wr) begin  // see R11 see R9
          st_d.state = MIC_HOLD;
        end
      end
      MIC_HOLD: begin
        st_d.state    = MIC_ENTER;
        st_d.global_irq_enable      = 1'b0;  // see R7
        st_d.vec      = 1'b1;  // see R7
        st_d.vec_addr = MIC_VECTOR_ADDR;  // see R7
        st_d.push     = 1'b1;  // see R7
        st_d.push_pc  = return_pc_i;  // see R12
        st_d.ev_stat[MIC_EV_TAKEN] = 1'b1;
      end
      MIC_ENTER: st_d.state = MIC_IDLE;
    endcase

    st_d.req = mic_pending(st_d);  // see R15
    st_d.nop = (st_d.state == MIC_HOLD) | gie_clr_wr;  // see R11
    st_d.irq = |(st_d.ev_stat & st_d.ev_en);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;  // see R3
    end else begin
      st_q <= st_d;
    end
  end

  assign core_irq_req_o  = st_q.req;
  assign core_nop_o      = st_q.nop;
  assign vector_load_o   = st_q.vec;
  assign vector_addr_o   = st_q.vec_addr;
  assign stack_push_o    = st_q.push;
  assign stack_push_pc_o = st_q.push_pc;
  assign stack_pop_o     = st_q.pop;
  assign irq_o           = st_q.irq;
  assign s_axi_awready   = st_q.awready;
  assign s_axi_wready    = st_q.wready;
  assign s_axi_bresp     = st_q.bresp;
  assign s_axi_bvalid    = st_q.bvalid;
  assign s_axi_arready   = st_q.arready;
  assign s_axi_rdata     = st_q.rdata;
  assign s_axi_rresp     = st_q.rresp;
  assign s_axi_rvalid    = st_q.rvalid;

  // ==========================================================================
  // checks
  sequence s_entry;
    vector_load_o && stack_push_o && vector_addr_o == MIC_VECTOR_ADDR && !st_q.global_irq_enable
    ##1 st_q.state == MIC_IDLE && !vector_load_o;
  endsequence

  a_reset_gie_off: assert property (@(posedge clk_i) disable iff (rst_i) // see R3
    $fell(rst_i) |-> !st_q.global_irq_enable && st_q.state == MIC_IDLE)
    else $error("global enable not clear after reset");

  a_gie_blocks_all: assert property (@(posedge clk_i) disable iff (rst_i) // see R2
    (st_q.state == MIC_IDLE && !st_q.global_irq_enable) |=> st_q.state == MIC_IDLE)
    else $error("request taken with global enable clear");

  a_entry_steps: assert property (@(posedge clk_i) disable iff (rst_i) // see R7
    (st_q.state == MIC_IDLE ##1 st_q.state == MIC_HOLD) |=> s_entry)
    else $error("entry did not push, vector and clear global enable");

  a_entry_latency: assert property (@(posedge clk_i) disable iff (rst_i) // see R9
    (st_q.state == MIC_IDLE && mic_pending(st_q) && !gie_clr_wr)
    |=> core_nop_o ##1 vector_load_o)
    else $error("entry not two cycles after a pending request");

  a_return_enable: assert property (@(posedge clk_i) disable iff (rst_i) // see R4
    (ret_from_irq_i && st_q.state != MIC_HOLD) |=> st_q.global_irq_enable && stack_pop_o)
    else $error("return did not set global enable");

  a_timer_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // see R10
    timer_zero_ovf_i |=> st_q.tmr_f && st_q.ev_stat[MIC_EV_TIMER])
    else $error("timer flag missed its event");

  a_host_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see R13
    (host_evt || (st_q.host_f && !(wr_fire && wsel == MIC_SEL_PFLAG))) |=> st_q.host_f)
    else $error("host flag lost without software clear");

  a_cmp_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // see R14
    cmp_evt |=> st_q.cmp_f ##1 (st_q.cmp_f || $past(wr_fire)))
    else $error("compare flag missed a change");

  a_peri_gated: assert property (@(posedge clk_i) disable iff (rst_i) // see R5
    (st_q.state == MIC_IDLE && !st_q.peripheral_irq_enable && !st_q.edge_f && !st_q.tmr_f && !st_q.port_f)
    |=> st_q.state == MIC_IDLE)
    else $error("peripheral request vectored with peripheral enable clear");

  a_gie_clear_nop: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
    (gie_clr_wr && st_q.state == MIC_IDLE) |=> core_nop_o && st_q.state == MIC_IDLE)
    else $error("no no-op after global enable clear");

  a_push_pc_only: assert property (@(posedge clk_i) disable iff (rst_i) // see R12
    stack_push_o |-> stack_push_pc_o == $past(return_pc_i) && $past(st_q.state) == MIC_HOLD)
    else $error("pushed value is not the return address");

  a_request_level: assert property (@(posedge clk_i) disable iff (rst_i) // see R15
    core_irq_req_o |-> st_q.global_irq_enable)
    else $error("request raised with global enable clear");

endmodule

// ### rtl/mic_pkg.sv
// constants, register map and types of the interrupt controller
package mic_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] MIC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] MIC_OFS_PFLAG  = 8'h04;
  localparam logic [7:0] MIC_OFS_PEN    = 8'h08;
  localparam logic [7:0] MIC_OFS_ISTAT  = 8'h0c;
  localparam logic [7:0] MIC_OFS_ICLR   = 8'h10;
  localparam logic [7:0] MIC_OFS_IEN    = 8'h14;

  // ==========================================================================
  // irq_control_reg fields
  localparam int MIC_CTRL_GIE_BIT   = 7;
  localparam int MIC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT  = 6;
  localparam int MIC_CTRL_TMREN_BIT = 5;
  localparam int MIC_CTRL_EDGEN_BIT = 4;
  localparam int MIC_CTRL_PRTEN_BIT = 3;
  localparam int MIC_CTRL_TMRF_BIT  = 2;
  localparam int MIC_CTRL_EDGF_BIT  = 1;
  localparam int MIC_CTRL_PRTF_BIT  = 0;

  // ==========================================================================
  // peripheral_flag_reg and peripheral_enable_reg fields
  localparam int MIC_HOST_BIT = 7;
  localparam int MIC_CMP_BIT  = 6;

  // ==========================================================================
  // event status layout
  localparam int MIC_EV_WIDTH  = 6;
  localparam int MIC_EV_EDGE   = 0;
  localparam int MIC_EV_TIMER  = 1;
  localparam int MIC_EV_PORT   = 2;
  localparam int MIC_EV_CMP    = 3;
  localparam int MIC_EV_HOST   = 4;
  localparam int MIC_EV_TAKEN  = 5;

  // ==========================================================================
  // core side, bus answers, variant
  localparam logic [12:0] MIC_VECTOR_ADDR   = 13'h0004;
  localparam logic [12:0] MIC_PC_RESET      = 13'h0000;
  localparam int          MIC_PORT_PINS     = 4;
  localparam int          MIC_CMP_OUTS      = 2;
  localparam logic [1:0]  MIC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  MIC_RESP_SLVERR   = 2'h2;
  localparam bit          MIC_HAS_HOST_PORT = 1'b1;

  typedef enum logic [2:0] {
    MIC_SEL_NONE,
    MIC_SEL_CTRL,
    MIC_SEL_PFLAG,
    MIC_SEL_PEN,
    MIC_SEL_ISTAT,
    MIC_SEL_ICLR,
    MIC_SEL_IEN
  } mic_sel_t;

  typedef enum logic [1:0] {
    MIC_IDLE,
    MIC_HOLD,
    MIC_ENTER
  } mic_state_t;

endpackage

// ### verification/mic_core_model.sv
// behavioural model of the processor core: fetch counter, return stack and return instruction
`timescale 1ns/1ps

module mic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [12:0] start_pc_i,
  input  wire logic        ret_cmd_i,
  input  wire logic        vector_load_i,
  input  wire logic [12:0] vector_addr_i,
  input  wire logic        stack_push_i,
  input  wire logic [12:0] stack_push_pc_i,
  input  wire logic        stack_pop_i,
  output logic             ret_from_irq_o,
  output logic [12:0]      return_pc_o
);
  logic [12:0] stack_q [8];
  logic [2:0]  sp_q;

  // =========
  // fetch: pc steps each cycle, jumps on vector entry or on return
  always_ff @(posedge clk_i) begin
    ret_from_irq_o <= ret_cmd_i & ~rst_i;
    if (rst_i) begin
      return_pc_o <= start_pc_i;
      sp_q        <= 3'h0;
    end else begin
      return_pc_o <= return_pc_o + 13'h1;
      if (vector_load_i) return_pc_o <= vector_addr_i;
      if (stack_push_i) begin
        stack_q[sp_q] <= stack_push_pc_i;
        sp_q          <= sp_q + 3'h1;
      end
      if (stack_pop_i) begin
        return_pc_o <= stack_q[sp_q - 3'h1];
        sp_q        <= sp_q - 3'h1;
      end
    end
  end
endmodule

// ### verification/mcu_interrupt_controller_tb.sv
// bench: register bus master, event stimulus and scoreboard
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module mcu_interrupt_controller_tb;
  import mic_pkg::*;
  logic        clk_i, rst_i, edge_irq_pin_i, timer_zero_ovf_i, host_port_done_i, ret_cmd;
  logic        ret_from_irq_i, core_irq_req_o, core_nop_o, vector_load_o, stack_push_o;
  logic        stack_pop_o, irq_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, prev_req;
  logic [1:0]  compare_out_i, s_axi_bresp, s_axi_rresp;
  logic [3:0]  port_change_pins_i, s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [12:0] start_pc, return_pc_i, vector_addr_o, stack_push_pc_o, prev_pc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [33:0] exp_q[$], e;
  logic [7:0]  ofs[6] = '{MIC_OFS_CTRL, MIC_OFS_PFLAG, MIC_OFS_PEN, MIC_OFS_ISTAT,
                          MIC_OFS_ICLR, MIC_OFS_IEN};
  int          fails, checked, entries, pops, nops, cyc, n;

  mic_irq_ctrl i_dut (.clk_i, .rst_i, .edge_irq_pin_i, .port_change_pins_i, .compare_out_i,
    .timer_zero_ovf_i, .host_port_done_i, .ret_from_irq_i, .return_pc_i, .core_irq_req_o,
    .core_nop_o, .vector_load_o, .vector_addr_o, .stack_push_o, .stack_push_pc_o, .stack_pop_o,
    .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  mic_core_model i_core (.clk_i, .rst_i, .start_pc_i(start_pc), .ret_cmd_i(ret_cmd),
    .vector_load_i(vector_load_o), .vector_addr_i(vector_addr_o), .stack_push_i(stack_push_o),
    .stack_push_pc_i(stack_push_pc_o), .stack_pop_i(stack_pop_o),
    .ret_from_irq_o(ret_from_irq_i), .return_pc_o(return_pc_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // =========
  // watcher: takes the oldest note at each bus answer, checks each vector entry
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
    if ((s_axi_bvalid & s_axi_bready) === 1'b1) begin
      e = exp_q.pop_front();
      `CHK({s_axi_bresp, 32'h0}, e)
    end
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) begin
      e = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, e)
    end
    if (vector_load_o === 1'b1) begin
      entries++;
      `CHK(vector_addr_o, MIC_VECTOR_ADDR)
      `CHK({stack_push_o, stack_push_pc_o}, {1'b1, prev_pc})
      `CHK(prev_req, 1'b1)
      `CHK(core_irq_req_o, 1'b0)
    end
    prev_req = core_irq_req_o;
    pops += int'(stack_pop_o === 1'b1);
    nops += int'(core_nop_o === 1'b1);
    prev_pc = return_pc_i;
  end

  // =========
  // bus and event tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = MIC_RESP_OKAY, input logic [3:0] s = 4'hf);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = MIC_RESP_OKAY);
    exp_q.push_back({r, 24'h0, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic fire(input int s);
    case (s)
      MIC_EV_EDGE:  edge_irq_pin_i <= 1'b1;
      MIC_EV_TIMER: timer_zero_ovf_i <= 1'b1;
      MIC_EV_PORT:  port_change_pins_i <= port_change_pins_i ^ 4'($urandom_range(15, 1));
      MIC_EV_CMP:   compare_out_i <= compare_out_i ^ 2'($urandom_range(3, 1));
      default:      host_port_done_i <= 1'b1;
    endcase
    @(posedge clk_i);
    timer_zero_ovf_i <= 1'b0;
    host_port_done_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    edge_irq_pin_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic leave;
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic settle(input int want);
    repeat (30) begin
      @(negedge clk_i);
      if (entries == want) break;
    end
    repeat (4) @(negedge clk_i);
    `CHK(entries, want)
    @(posedge clk_i);
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // =========
  // main sequence
  initial begin
    void'($urandom(54));
    start_pc = 13'($urandom);
    {rst_i, edge_irq_pin_i, timer_zero_ovf_i, host_port_done_i, ret_cmd} = 5'h10;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    port_change_pins_i = 4'($urandom);
    compare_out_i = 2'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(8'h18, 8'h00, MIC_RESP_SLVERR);
    wr(8'h18, 8'hff, MIC_RESP_SLVERR);
    wr(MIC_OFS_IEN, 8'hff, MIC_RESP_OKAY, 4'he);
    wr(MIC_OFS_ISTAT, 8'hff);
    rd(MIC_OFS_IEN, 8'h00);
    for (int s = 0; s < 5; s++) fire(s);
    rd(MIC_OFS_CTRL, 8'h07);
    rd(MIC_OFS_PFLAG, 8'hc0);
    rd(MIC_OFS_ISTAT, 8'h1f);
    wr(MIC_OFS_CTRL, 8'h24);
    settle(0);
    wr(MIC_OFS_CTRL, 8'ha4);
    settle(1);
    rd(MIC_OFS_CTRL, 8'h24);
    wr(MIC_OFS_CTRL, 8'h20);
    leave();
    `CHK(pops, 1)
    rd(MIC_OFS_CTRL, 8'ha0);
    n = nops;
    wr(MIC_OFS_CTRL, 8'h20);
    repeat (3) @(posedge clk_i);
    `CHK(nops, n + 1)
    fire(MIC_EV_TIMER);
    settle(1);
    wr(MIC_OFS_CTRL, 8'ha4);
    settle(2);
    wr(MIC_OFS_CTRL, 8'h20);
    leave();
    for (int b = MIC_CMP_BIT; b <= MIC_HOST_BIT; b++) begin
      wr(MIC_OFS_CTRL, 8'h80);
      wr(MIC_OFS_PEN, 8'(1 << b));
      fire(b == MIC_HOST_BIT ? MIC_EV_HOST : MIC_EV_CMP);
      settle(b - 4);
      wr(MIC_OFS_CTRL, 8'hc0);
      settle(b - 3);
      wr(MIC_OFS_PFLAG, 8'h00);
      leave();
    end
    wr(MIC_OFS_CTRL, 8'h90);
    edge_irq_pin_i <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (vector_load_o !== 1'b1 && n < 30);
    `CHK(n inside {[3:7]}, 1'b1)
    @(posedge clk_i);
    edge_irq_pin_i <= 1'b0;
    wr(MIC_OFS_CTRL, 8'h10);
    leave();
    wr(MIC_OFS_ICLR, 8'h3f);
    wr(MIC_OFS_IEN, 8'h02);
    fire(MIC_EV_TIMER);
    `CHK(irq_o, 1'b1)
    rd(MIC_OFS_ISTAT, 8'h02);
    wr(MIC_OFS_IEN, 8'h00);
    `CHK(irq_o, 1'b0)
    wr(MIC_OFS_IEN, 8'h02);
    `CHK(irq_o, 1'b1)
    wr(MIC_OFS_ICLR, 8'h02);
    `CHK(irq_o, 1'b0)
    rd(MIC_OFS_ICLR, 8'h00);
    conclude();
  end
endmodule
